/* File: btc_pkg.sv */
package btc_pkg;

  // Register offsets on the plain register port (byte addresses).
  localparam logic [7:0] BTC_OFF_SCR      = 8'h00;  // Debug status/control.
  localparam logic [7:0] BTC_OFF_BKPT_HI  = 8'h01;  // Simple break address high.
  localparam logic [7:0] BTC_OFF_BKPT_LO  = 8'h02;  // Simple break address low.
  localparam logic [7:0] BTC_OFF_CMPA_HI  = 8'h03;  // Comparator A high.
  localparam logic [7:0] BTC_OFF_CMPA_LO  = 8'h04;  // Comparator A low.
  localparam logic [7:0] BTC_OFF_CMPB_HI  = 8'h05;  // Comparator B high.
  localparam logic [7:0] BTC_OFF_CMPB_LO  = 8'h06;  // Comparator B low.
  localparam logic [7:0] BTC_OFF_FIFO_HI  = 8'h07;  // FIFO port high byte.
  localparam logic [7:0] BTC_OFF_FIFO_LO  = 8'h08;  // FIFO port low byte.
  localparam logic [7:0] BTC_OFF_CTRL     = 8'h09;  // Trace control.
  localparam logic [7:0] BTC_OFF_TRIG     = 8'h0A;  // Trigger control.
  localparam logic [7:0] BTC_OFF_STAT     = 8'h0B;  // Trace status.

  // Status/control field positions.
  localparam int BTC_SCR_BKEN = 7;  // Simple break enable.
  localparam int BTC_SCR_FTS  = 6;  // Force (1) or tag (0).

  // Trace control field positions.
  localparam int BTC_CTL_EN    = 7;  // Trace unit enable.
  localparam int BTC_CTL_ARM   = 6;  // Arm.
  localparam int BTC_CTL_TAG   = 5;  // Tag-type CPU request.
  localparam int BTC_CTL_BRKEN = 4;  // CPU break request enable.
  localparam int BTC_CTL_RWA   = 3;  // Read/write match value A.
  localparam int BTC_CTL_RW_QUALIFY_ENABLE_A = 2;  // Read/write qualify A.
  localparam int BTC_CTL_RWB   = 1;  // Read/write match value B.
  localparam int BTC_CTL_RWBEN = 0;  // Read/write qualify B.

  // Trigger control field positions.
  localparam int BTC_TRG_SEL   = 7;  // Opcode tracking select.
  localparam int BTC_TRG_BEGIN = 6;  // Begin (1) or end (0) trace.

  // Reset values.
  localparam logic [7:0] BTC_RST_BYTE = 8'h00;
  localparam logic [15:0] BTC_RST_WORD = 16'h0000;

  // Trigger mode codes in the low nibble of trigger control.
  localparam logic [3:0] BTC_M_A_ONLY   = 4'h0;
  localparam logic [3:0] BTC_M_A_OR_B   = 4'h1;
  localparam logic [3:0] BTC_M_A_THEN_B = 4'h2;
  localparam logic [3:0] BTC_M_EV_B     = 4'h3;
  localparam logic [3:0] BTC_M_A_THEN_EV_B = 4'h4;
  localparam logic [3:0] BTC_M_A_AND_B  = 4'h5;
  localparam logic [3:0] BTC_M_A_NAND_B = 4'h6;
  localparam logic [3:0] BTC_M_INSIDE   = 4'h7;
  localparam logic [3:0] BTC_M_OUTSIDE  = 4'h8;

  // Begin-trace skip window: bus cycles after the trigger that are not stored.
  localparam logic [1:0] BTC_BEGIN_SKIP = 2'h2;

  // Depth of the opcode tracking window in the instruction queue.
  localparam int BTC_QUEUE_DEPTH = 3;

  // Trace run phase.
  typedef enum logic [1:0] {BTC_IDLE, BTC_WAIT_A, BTC_RUN} btc_phase_t;

endpackage

/* File: btc_top.sv */
`timescale 1ns/1ps

// Functional notes
// - Simple break compares bus address to 16-bit value.
// - Forced type: any access breaks at boundary.
// - Tagged type: marked opcode breaks at queue end.
// - Enable resets to zero and gates all requests.
// - Select one forces, zero tags.
// - Eight-entry FIFO captures address or data.
// - Two comparators, each with read/write qualify.
// - Opcode tracking triggers only on execution, except in the range modes, which use the bus directly.
// - Comparators muted during serial debug accesses.
// - A compares address; B address or data; ranges.
// - Full modes pick write bus when RW_QUALIFY_ENABLE_A, RW_MATCH_VALUE_A=0.
// - Match breaks, stores data, begins or ends.
// - Count reports valid words; eight means full.
// - High then low read; low read shifts.
// - Event modes store data in low half.
// - Skip change-of-flow at trigger and two after.
// - End trace keeps triggering change-of-flow last.
// - Disarmed low read pushes last opcode address.
// - Taken conditional branch stores its own address.
// - Indirect jumps and returns store destination.
// - Tag request rides queue, replaced by halt.
// - Each comparator tracks opcodes independently.
module btc_top
  import btc_pkg::*;
#(
  parameter int DEPTH = 8  // FIFO entries.
) (
  input  wire logic        mclk,             // Bus clock, 250 MHz.
  input  wire logic        reset,            // Synchronous reset, active high.
  input  wire logic [7:0]  reg_addr,         // Register address.
  input  wire logic [7:0]  reg_wdata,        // Register write data.
  input  wire logic        reg_write,        // Write strobe.
  input  wire logic        reg_read,         // Read strobe.
  output logic      [7:0]  reg_rdata,        // Read data, one cycle after strobe.
  input  wire logic        bus_valid,        // CPU bus cycle present.
  input  wire logic [15:0] bus_addr,         // CPU address.
  input  wire logic        bus_rw,           // One for read, zero for write.
  input  wire logic [7:0]  bus_rdata,        // CPU read data bus.
  input  wire logic [7:0]  bus_wdata,        // CPU write data bus.
  input  wire logic        bus_debug,        // Access made by the serial debug controller.
  input  wire logic        opcode_fetch,     // Cycle is an opcode fetch.
  input  wire logic        opcode_exec,      // Queue end opcode is executing.
  input  wire logic        insn_boundary,    // Instruction boundary.
  input  wire logic        cof_valid,        // Change-of-flow event to store.
  input  wire logic [15:0] cof_addr,         // Address chosen by the CPU for it.
  output logic             force_break,      // Forced break to the CPU.
  output logic             tag_fetch,        // Tag for the opcode being fetched.
  output logic             halt_substitute   // Queue end opcode becomes the halt opcode.
);

  // All state of the block in one record.
  typedef struct packed {
    logic [7:0]        scr;          // Status/control of the simple break.
    logic [15:0]       bkpt;         // Simple break address.
    logic [15:0]       cmpa;         // Comparator A value.
    logic [15:0]       cmpb;         // Comparator B value.
    logic [7:0]        ctrl;         // Trace control.
    logic [7:0]        trig;         // Trigger control.
    logic [DEPTH-1:0][15:0] fifo;    // Entry zero is the port.
    logic [3:0]        count;        // Valid words.
    logic              af;           // Comparator A qualified match seen.
    logic              bf;           // Comparator B qualified match seen.
    btc_phase_t        phase;        // Trace run phase.
    logic [1:0]        skip;         // Cycles of change-of-flow still to skip.
    logic [BTC_QUEUE_DEPTH-1:0] qa;  // Tracking tags for comparator A.
    logic [BTC_QUEUE_DEPTH-1:0] qb;  // Tracking tags for comparator B.
    logic [BTC_QUEUE_DEPTH-1:0] qt;  // CPU tag requests in the queue.
    logic [15:0]       last_op;      // Address of the latest opcode fetch.
    logic              pending;      // Forced break awaiting a boundary.
    logic [7:0]        rdata;        // Registered read data.
    logic              force_out;    // Registered force output.
    logic              tag_out;      // Registered tag output.
    logic              halt_out;     // Registered halt output.
  } btc_state_t;

  btc_state_t st;       // Current state.
  btc_state_t next_st;  // Next state.

  // Decoded controls.
  logic       mode_event;   // Event-only modes.
  logic       mode_full;    // Address plus data modes.
  logic       hit_a;        // Comparator A qualified match.
  logic       hit_b;        // Comparator B qualified match.
  logic       ex_a;         // A match after optional opcode tracking.
  logic       ex_b;         // B match after optional opcode tracking.
  logic       trigger;      // Mode-level trigger.
  logic       brk_req;      // Trace unit CPU break request.
  logic [7:0] data_b;       // Data seen by comparator B.
  logic       simple_hit;   // Simple break address hit.
  logic       push;         // Push into the FIFO this cycle.
  logic [15:0] push_val;    // Value pushed.
  logic       pop;          // Low port read shifts the FIFO.

  // Compare, qualify and decide the trigger for the current bus cycle.
  always_comb begin
    mode_event = (st.trig[3:0] == BTC_M_EV_B) || (st.trig[3:0] == BTC_M_A_THEN_EV_B);
    mode_full  = (st.trig[3:0] == BTC_M_A_AND_B) || (st.trig[3:0] == BTC_M_A_NAND_B);
    // Full modes look at the write bus whenever comparator A is qualified on writes.
    data_b = (st.ctrl[BTC_CTL_RW_QUALIFY_ENABLE_A] && !st.ctrl[BTC_CTL_RWA]) ? bus_wdata : bus_rdata;
    // Debug controller accesses never match comparator A or B.
    hit_a = bus_valid && !bus_debug && (bus_addr == st.cmpa)
            && (!st.ctrl[BTC_CTL_RW_QUALIFY_ENABLE_A] || (bus_rw == st.ctrl[BTC_CTL_RWA]));
    if (mode_full) begin
      hit_b = bus_valid && !bus_debug && (data_b == st.cmpb[7:0]);
    end else begin
      hit_b = bus_valid && !bus_debug && (bus_addr == st.cmpb)
              && (!st.ctrl[BTC_CTL_RWBEN] || (bus_rw == st.ctrl[BTC_CTL_RWB]));
    end
    // Tracking: the tag at the queue end fires only when that opcode executes.
    if (st.trig[BTC_TRG_SEL]) begin
      ex_a = opcode_exec && st.qa[BTC_QUEUE_DEPTH-1];
      ex_b = opcode_exec && st.qb[BTC_QUEUE_DEPTH-1];
    end else begin
      ex_a = hit_a;
      ex_b = hit_b;
    end
    unique case (st.trig[3:0])
      BTC_M_A_ONLY:      trigger = ex_a;
      BTC_M_A_OR_B:      trigger = ex_a || ex_b;
      BTC_M_A_THEN_B:    trigger = (st.af || ex_a) && ex_b && st.af;
      BTC_M_EV_B:        trigger = ex_b;
      BTC_M_A_THEN_EV_B: trigger = st.af && ex_b;
      BTC_M_A_AND_B:     trigger = ex_a && hit_b;
      BTC_M_A_NAND_B:    trigger = ex_a && !hit_b;
      BTC_M_INSIDE:      trigger = bus_valid && !bus_debug
                                   && bus_addr >= st.cmpa && bus_addr <= st.cmpb;
      BTC_M_OUTSIDE:     trigger = bus_valid && !bus_debug
                                   && (bus_addr < st.cmpa || bus_addr > st.cmpb);
      default:           trigger = 1'b0;
    endcase
    // Tag breaks in full modes follow the address match alone.
    brk_req = st.ctrl[BTC_CTL_EN] && st.ctrl[BTC_CTL_ARM] && st.ctrl[BTC_CTL_BRKEN]
              && ((mode_full && st.ctrl[BTC_CTL_TAG]) ? hit_a : trigger);
    simple_hit = bus_valid && (bus_addr == st.bkpt);
  end

  // Next state: registers, trace run, FIFO and CPU requests.
  always_comb begin
    next_st = st;
    push = 1'b0;
    push_val = cof_addr;
    pop = reg_read && (reg_addr == BTC_OFF_FIFO_LO);

    // Register writes; the arm bit with the enable bit set also opens a fresh run.
    if (reg_write) begin
      unique case (reg_addr)
        BTC_OFF_SCR:     next_st.scr = reg_wdata;
        BTC_OFF_BKPT_HI: next_st.bkpt[15:8] = reg_wdata;
        BTC_OFF_BKPT_LO: next_st.bkpt[7:0] = reg_wdata;
        BTC_OFF_CMPA_HI: next_st.cmpa[15:8] = reg_wdata;
        BTC_OFF_CMPA_LO: next_st.cmpa[7:0] = reg_wdata;
        BTC_OFF_CMPB_HI: next_st.cmpb[15:8] = reg_wdata;
        BTC_OFF_CMPB_LO: next_st.cmpb[7:0] = reg_wdata;
        BTC_OFF_TRIG:    next_st.trig = reg_wdata;
        BTC_OFF_CTRL: begin
          next_st.ctrl = reg_wdata;
          if (reg_wdata[BTC_CTL_ARM] && reg_wdata[BTC_CTL_EN]) begin
            next_st.af = 1'b0;
            next_st.bf = 1'b0;
            next_st.count = 4'h0;
            next_st.phase = BTC_WAIT_A;
          end else begin
            next_st.phase = BTC_IDLE;
            next_st.ctrl[BTC_CTL_ARM] = 1'b0;
            // A run stopped by hand before full leaves its words one place lower.
            if (st.phase != BTC_IDLE && st.count != 4'(DEPTH)) begin
              for (int i = 0; i < DEPTH-1; i++) next_st.fifo[i] = st.fifo[i+1];
              next_st.fifo[DEPTH-1] = BTC_RST_WORD;
            end
          end
        end
        default: ;
      endcase
    end

    // Opcode tracking pipes advance with each fetch, one lane per comparator and one for CPU tag requests.
    if (opcode_fetch) begin
      next_st.qa = {st.qa[BTC_QUEUE_DEPTH-2:0], hit_a};
      next_st.qb = {st.qb[BTC_QUEUE_DEPTH-2:0], hit_b};
      next_st.qt = {st.qt[BTC_QUEUE_DEPTH-2:0], tag_fetch_c()};
      next_st.last_op = bus_addr;
    end

    // Armed trace run.
    if (st.phase != BTC_IDLE) begin
      if (ex_a) next_st.af = 1'b1;
      if (ex_b) next_st.bf = 1'b1;
      if (mode_event) begin
        // Event modes are always begin-type and store data bytes.
        if (trigger) begin
          push = 1'b1;
          push_val = {8'h00, (bus_rw ? bus_rdata : bus_wdata)};
        end
      end else if (st.trig[BTC_TRG_BEGIN]) begin
        if (st.phase == BTC_WAIT_A && trigger) begin
          next_st.phase = BTC_RUN;
          next_st.skip = BTC_BEGIN_SKIP;
        end else if (st.phase == BTC_RUN) begin
          if (st.skip != 2'h0) next_st.skip = st.skip - 2'h1;
          else if (cof_valid) push = 1'b1;
        end
      end else begin
        // End trace stores until trigger, including a trigger's own flow change.
        if (cof_valid) push = 1'b1;
        if (trigger) begin
          next_st.phase = BTC_IDLE;
          next_st.ctrl[BTC_CTL_ARM] = 1'b0;
        end
      end
    end else if (pop) begin
      // Profiling while disarmed: each low read records the latest opcode.
      push = 1'b1;
      push_val = st.last_op;
    end

    // Shift register FIFO; a pop moves the next word to the port.
    if (pop) begin
      for (int i = 0; i < DEPTH-1; i++) next_st.fifo[i] = st.fifo[i+1];
      next_st.fifo[DEPTH-1] = BTC_RST_WORD;
      if (st.count != 4'h0 && st.phase == BTC_IDLE) next_st.count = st.count - 4'h1;
    end
    if (push) begin
      for (int i = 0; i < DEPTH-1; i++) next_st.fifo[i] = st.fifo[i+1];
      next_st.fifo[DEPTH-1] = push_val;
      if (st.count != 4'(DEPTH)) next_st.count = next_st.count + 4'h1;
      // Begin and event runs end when full.
      if (st.phase != BTC_IDLE && (mode_event || st.trig[BTC_TRG_BEGIN])
          && st.count == 4'(DEPTH-1)) begin
        next_st.phase = BTC_IDLE;
        next_st.ctrl[BTC_CTL_ARM] = 1'b0;
      end
    end

    // Simple forced break waits for the next boundary.
    if (st.scr[BTC_SCR_BKEN] && st.scr[BTC_SCR_FTS] && simple_hit) begin
      next_st.pending = 1'b1;
    end
    if (brk_req && !st.ctrl[BTC_CTL_TAG]) next_st.pending = 1'b1;
    next_st.force_out = 1'b0;
    if ((st.pending || next_st.pending) && insn_boundary) begin
      next_st.force_out = 1'b1;
      next_st.pending = 1'b0;
    end
    next_st.tag_out = tag_fetch_c();
    next_st.halt_out = opcode_exec && st.qt[BTC_QUEUE_DEPTH-1];

    // Read data for the cycle after the strobe.
    next_st.rdata = 8'h00;
    if (reg_read) begin
      unique case (reg_addr)
        BTC_OFF_SCR:     next_st.rdata = st.scr;
        BTC_OFF_BKPT_HI: next_st.rdata = st.bkpt[15:8];
        BTC_OFF_BKPT_LO: next_st.rdata = st.bkpt[7:0];
        BTC_OFF_CMPA_HI: next_st.rdata = st.cmpa[15:8];
        BTC_OFF_CMPA_LO: next_st.rdata = st.cmpa[7:0];
        BTC_OFF_CMPB_HI: next_st.rdata = st.cmpb[15:8];
        BTC_OFF_CMPB_LO: next_st.rdata = st.cmpb[7:0];
        BTC_OFF_FIFO_HI: next_st.rdata = mode_event ? 8'h00 : st.fifo[0][15:8];
        BTC_OFF_FIFO_LO: next_st.rdata = st.fifo[0][7:0];
        BTC_OFF_CTRL:    next_st.rdata = st.ctrl;
        BTC_OFF_TRIG:    next_st.rdata = st.trig;
        BTC_OFF_STAT:    next_st.rdata = {st.af, st.bf, (st.phase != BTC_IDLE),
                                          1'b0, st.count};
        default:         next_st.rdata = 8'h00;
      endcase
    end

    if (reset) begin
      next_st = '0;
      next_st.phase = BTC_IDLE;
    end
  end

  // Tag for an opcode fetched now, from the simple break or a tag-type request.
  function automatic logic tag_fetch_c();
    return opcode_fetch
           && ((st.scr[BTC_SCR_BKEN] && !st.scr[BTC_SCR_FTS] && simple_hit)
               || (brk_req && st.ctrl[BTC_CTL_TAG]));
  endfunction

  // One register for the whole record keeps every output on a flip-flop.
  always_ff @(posedge mclk) begin
    st <= next_st;
  end

  assign reg_rdata       = st.rdata;
  assign force_break     = st.force_out;
  assign tag_fetch       = st.tag_out;
  assign halt_substitute = st.halt_out;

endmodule // btc_top

/* File: btc_checker.sv */
`timescale 1ns/1ps

// Port-level checks; shadows of a few control bits tell the checker what the block may do.
module btc_checker
  import btc_pkg::*;
(
  input wire logic       mclk,           // Bus clock.
  input wire logic       reset,          // Synchronous reset.
  input wire logic [7:0] reg_addr,       // Register address.
  input wire logic [7:0] reg_wdata,      // Register write data.
  input wire logic       reg_write,      // Write strobe.
  input wire logic       reg_read,       // Read strobe.
  input wire logic [7:0] reg_rdata,      // Read data.
  input wire logic       opcode_fetch,   // Opcode fetch cycle.
  input wire logic       opcode_exec,    // Queue end executes.
  input wire logic       insn_boundary,  // Instruction boundary.
  input wire logic       force_break,    // Forced break.
  input wire logic       tag_fetch,      // Fetch tag.
  input wire logic       halt_substitute // Halt substitution.
);
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (reset);
  logic simple_on; // Simple break enable as last written.
  logic trace_brk; // Trace enable and break request as last written.
  logic ev_mode;   // An event-only mode is selected.
  // Shadows follow writes, so the checker knows when breaks must stay quiet.
  always_ff @(posedge mclk) begin
    if (reset) begin
      simple_on <= 1'b0;
      trace_brk <= 1'b0;
      ev_mode   <= 1'b0;
    end else if (reg_write && reg_addr == BTC_OFF_SCR) begin
      simple_on <= reg_wdata[BTC_SCR_BKEN];
    end else if (reg_write && reg_addr == BTC_OFF_CTRL) begin
      trace_brk <= reg_wdata[BTC_CTL_EN] & reg_wdata[BTC_CTL_BRKEN];
    end else if (reg_write && reg_addr == BTC_OFF_TRIG) begin
      ev_mode <= reg_wdata[3:0] == BTC_M_EV_B || reg_wdata[3:0] == BTC_M_A_THEN_EV_B;
    end
  end
  rdata_idle_a: assert property (!reg_read |=> reg_rdata == 8'h00)
    else $error("read data not zero outside a read answer");
  count_max_a: assert property (
    reg_read && reg_addr == BTC_OFF_STAT |=> reg_rdata[3:0] <= 4'h8)
    else $error("fifo word count above eight");
  event_high_a: assert property (
    ev_mode && reg_read && reg_addr == BTC_OFF_FIFO_HI |=> reg_rdata == 8'h00)
    else $error("high fifo half used in event mode");
  scr_readback_a: assert property (
    (reg_write && reg_addr == BTC_OFF_SCR) ##2 (reg_read && reg_addr == BTC_OFF_SCR)
    |=> reg_rdata[7:6] == $past(reg_wdata[7:6], 3)) else $error("break control bits not kept");
  fb_boundary_a: assert property (force_break |-> $past(insn_boundary))
    else $error("forced break away from a boundary");
  tag_fetch_a: assert property (tag_fetch |-> $past(opcode_fetch))
    else $error("tag without an opcode fetch");
  halt_exec_a: assert property (halt_substitute |-> $past(opcode_exec))
    else $error("halt substitution without execution");
  break_quiet_a: assert property (
    (!simple_on && !trace_brk) [*3] |-> !force_break && !tag_fetch)
    else $error("break request while disabled");
  cover property (force_break);
  cover property (halt_substitute);
  cover property (reg_read && reg_addr == BTC_OFF_STAT ##1 reg_rdata[3:0] == 4'h8);
endmodule // btc_checker

bind btc_top btc_checker chk_u (.mclk, .reset, .reg_addr, .reg_wdata, .reg_write, .reg_read,
  .reg_rdata, .opcode_fetch, .opcode_exec, .insn_boundary, .force_break, .tag_fetch,
  .halt_substitute);

/* File: btc_cpu_model.sv */
`timescale 1ns/1ps

// CPU stand-in: one bus cycle per call; idle lines are scrambled so stale values never match.
module btc_cpu_model (
  output logic        bus_valid,     // Bus cycle present.
  output logic [15:0] bus_addr,      // CPU address.
  output logic        bus_rw,        // One for read.
  output logic [7:0]  bus_rdata,     // Read data.
  output logic [7:0]  bus_wdata,     // Write data.
  output logic        bus_debug,     // Debug controller access.
  output logic        opcode_fetch,  // Opcode fetch.
  output logic        opcode_exec,   // Queue end executes.
  output logic        insn_boundary, // Instruction boundary.
  output logic        cof_valid,     // Change-of-flow event.
  output logic [15:0] cof_addr,      // Change-of-flow address.
  input  wire logic   mclk           // Bus clock.
);
  initial begin
    {bus_valid, bus_addr, bus_rw, bus_rdata, bus_wdata} = '0;
    {bus_debug, opcode_fetch, opcode_exec, insn_boundary, cof_valid, cof_addr} = '0;
  end
  // Flags are {debug, fetch, exec, boundary, change-of-flow}; the CPU picks the stored address.
  task automatic cyc(input logic [15:0] a, input logic [7:0] d, input logic [4:0] f,
                     input logic [15:0] ca);
    @(posedge mclk);
    {bus_valid, bus_rw, bus_addr, bus_rdata, bus_wdata} <= {2'b11, a, d, ~d};
    {bus_debug, opcode_fetch, opcode_exec, insn_boundary, cof_valid} <= f;
    cof_addr <= ca;
  endtask
  // A write cycle: the write bus carries d, the read bus its inverse.
  task automatic wcyc(input logic [15:0] a, input logic [7:0] d);
    @(posedge mclk);
    {bus_valid, bus_rw, bus_addr, bus_rdata, bus_wdata} <= {2'b10, a, ~d, d};
    {bus_debug, opcode_fetch, opcode_exec, insn_boundary, cof_valid} <= 5'b00000;
    cof_addr <= a;
  endtask
  // Idle cycles clear bus_valid and the flag lines and invert the address and data lines each cycle; bus_rw keeps its value.
  task automatic idle(input int n);
    repeat (n) begin
      @(posedge mclk);
      {bus_valid, bus_debug, opcode_fetch, opcode_exec, insn_boundary, cof_valid} <= '0;
      {bus_addr, bus_rdata, bus_wdata, cof_addr} <= ~{bus_addr, bus_rdata, bus_wdata, cof_addr};
    end
  endtask
endmodule // btc_cpu_model

/* File: tb_breakpoint_trace_capture.sv */
`timescale 1ns/1ps

// Self-checking bench: register tasks on the plain port, CPU traffic through the model.
module tb_breakpoint_trace_capture import btc_pkg::*;;
  logic        mclk, reset, reg_write, reg_read;             // Clock, reset, strobes.
  logic [7:0]  reg_addr, reg_wdata, reg_rdata, v;            // Register port and scratch.
  logic        bus_valid, bus_rw, bus_debug, cof_valid;      // CPU bus qualifiers.
  logic        opcode_fetch, opcode_exec, insn_boundary;     // Queue events.
  logic [15:0] bus_addr, cof_addr;                           // Addresses.
  logic [7:0]  bus_rdata, bus_wdata;                         // Data buses.
  logic        force_break, tag_fetch, halt_substitute;      // CPU requests.
  int          fails = 0, tests_run = 0, fb_n = 0, tg_n = 0, hs_n = 0, i;
  btc_top #(.DEPTH(8)) dut_u (.mclk, .reset, .reg_addr, .reg_wdata, .reg_write, .reg_read,
    .reg_rdata, .bus_valid, .bus_addr, .bus_rw, .bus_rdata, .bus_wdata, .bus_debug,
    .opcode_fetch, .opcode_exec, .insn_boundary, .cof_valid, .cof_addr, .force_break,
    .tag_fetch, .halt_substitute);
  btc_cpu_model cpu_u (.bus_valid, .bus_addr, .bus_rw, .bus_rdata, .bus_wdata, .bus_debug,
    .opcode_fetch, .opcode_exec, .insn_boundary, .cof_valid, .cof_addr, .mclk);
  initial begin
    mclk = 1'b0;
    forever #2 mclk = ~mclk;
  end
  // Requests are counted as pulses, since they stand for a single cycle.
  always @(posedge mclk) begin
    if (force_break === 1'b1) fb_n <= fb_n + 1;
    if (tag_fetch === 1'b1) tg_n <= tg_n + 1;
    if (halt_substitute === 1'b1) hs_n <= hs_n + 1;
  end
  task automatic tally_and_finish();
    $display("fails=%0d tests_run=%0d", fails, tests_run);
    if (fails == 0 && tests_run > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
    tests_run++;
    if (got !== exp) begin
      fails++;
      $display("BAD %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge mclk);
    {reg_write, reg_addr, reg_wdata} <= {1'b1, a, d};
    @(posedge mclk);
    reg_write <= 1'b0;
  endtask
  // Read data stand only in the cycle after the strobe, so they are taken just after that edge.
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge mclk);
    {reg_read, reg_addr} <= {1'b1, a};
    @(posedge mclk);
    reg_read <= 1'b0;
    #1 d = reg_rdata;
  endtask
  task automatic rdc(input string what, input logic [7:0] a, input logic [7:0] exp);
    logic [7:0] d;
    rd(a, d);
    chk(what, {8'h00, exp}, {8'h00, d});
  endtask
  // An access followed by a boundary, then time for the request to show.
  task automatic brk(input logic [15:0] a);
    cpu_u.cyc(a, 8'h5A, 5'b00000, 16'h0000);
    cpu_u.cyc(16'h1000, 8'h5A, 5'b00010, 16'h0000);
    cpu_u.idle(6);
  endtask
  initial begin
    reset = 1'b1;
    {reg_addr, reg_wdata, reg_write, reg_read} = '0;
    repeat (6) @(posedge mclk);
    reset <= 1'b0;
    for (i = 0; i < 12; i++) if (i != 7 && i != 8) rdc("reset value", 8'(i), 8'h00);
    wr(8'h0C, 8'hFF);
    rdc("unmapped", 8'h0C, 8'h00);
    wr(BTC_OFF_BKPT_HI, 8'h80);
    wr(BTC_OFF_BKPT_LO, 8'h01);
    wr(BTC_OFF_SCR, 8'h40);
    brk(16'h8001);
    chk("break while off", 16'h0, 16'(fb_n));
    wr(BTC_OFF_SCR, 8'hC0);
    rdc("break control", BTC_OFF_SCR, 8'hC0);
    brk(16'h0001);
    chk("top bit differs", 16'h0, 16'(fb_n));
    brk(16'h8001);
    chk("forced break", 16'h1, 16'(fb_n));
    wr(BTC_OFF_SCR, 8'h80);
    cpu_u.cyc(16'h8001, 8'h00, 5'b01000, 16'h0000);
    cpu_u.idle(4);
    chk("tag", 16'h1, 16'(tg_n));
    chk("no force when tagged", 16'h1, 16'(fb_n));
    repeat (6) cpu_u.cyc(16'h8002, 8'h00, 5'b01100, 16'h0000);
    cpu_u.idle(4);
    chk("halt", 16'h1, 16'(hs_n));
    wr(BTC_OFF_SCR, 8'h00);
    // Event-only capture, with a debug access at the match address in the middle.
    wr(BTC_OFF_CMPB_HI, 8'h20);
    wr(BTC_OFF_CMPB_LO, 8'h40);
    wr(BTC_OFF_TRIG, {4'h0, BTC_M_EV_B});
    wr(BTC_OFF_CTRL, 8'hC0);
    for (i = 0; i < 8; i++) begin
      if (i == 3) cpu_u.cyc(16'h2040, 8'hEE, 5'b10000, 16'h0000);
      cpu_u.cyc(16'h2040, 8'(16 + i), 5'b00000, 16'h0000);
    end
    cpu_u.idle(4);
    rd(BTC_OFF_STAT, v);
    chk("full count", 16'h8, {12'h000, v[3:0]});
    for (i = 0; i < 8; i++) begin
      rdc("event high", BTC_OFF_FIFO_HI, 8'h00);
      rdc("event low", BTC_OFF_FIFO_LO, 8'(16 + i));
    end
    // Profiling while disarmed: the first eight values are stale.
    wr(BTC_OFF_CTRL, 8'h00);
    wr(BTC_OFF_TRIG, 8'h00);
    cpu_u.cyc(16'h1234, 8'h00, 5'b01000, 16'h0000);
    cpu_u.idle(2);
    repeat (8) rd(BTC_OFF_FIFO_LO, v);
    rdc("profile high", BTC_OFF_FIFO_HI, 8'h12);
    rdc("profile low", BTC_OFF_FIFO_LO, 8'h34);
    // Begin trace: the trigger and the two cycles after it are not stored.
    wr(BTC_OFF_CMPA_HI, 8'h30);
    wr(BTC_OFF_CMPA_LO, 8'h00);
    wr(BTC_OFF_TRIG, 8'h40);
    wr(BTC_OFF_CTRL, 8'hC0);
    cpu_u.cyc(16'h3000, 8'h00, 5'b00001, 16'hAAAA);
    cpu_u.cyc(16'h3001, 8'h00, 5'b00001, 16'hBBBB);
    cpu_u.cyc(16'h3002, 8'h00, 5'b00001, 16'hCCCC);
    cpu_u.cyc(16'h3003, 8'h00, 5'b00001, 16'h4400);
    cpu_u.cyc(16'h3004, 8'h00, 5'b00001, 16'h4401);
    cpu_u.idle(4);
    rd(BTC_OFF_STAT, v);
    chk("begin count", 16'h2, {12'h000, v[3:0]});
    wr(BTC_OFF_CTRL, 8'h80);
    repeat (5) rd(BTC_OFF_FIFO_LO, v);
    rdc("first high", BTC_OFF_FIFO_HI, 8'h44);
    rdc("first low", BTC_OFF_FIFO_LO, 8'h00);
    rdc("second high", BTC_OFF_FIFO_HI, 8'h44);
    rdc("second low", BTC_OFF_FIFO_LO, 8'h01);
    // Full mode, A qualified on writes: B must watch the write bus.
    wr(BTC_OFF_CMPA_HI, 8'h50);
    wr(BTC_OFF_CMPB_LO, 8'h77);
    wr(BTC_OFF_TRIG, {4'h0, BTC_M_A_AND_B});
    wr(BTC_OFF_CTRL, 8'hD4);
    cpu_u.cyc(16'h5000, 8'h88, 5'b00000, 16'h0000);
    cpu_u.wcyc(16'h5000, 8'h77);
    cpu_u.cyc(16'h1000, 8'h5A, 5'b00010, 16'h0000);
    cpu_u.idle(4);
    chk("trace break", 16'h2, 16'(fb_n));
    // Opcode tracking: a fetch at A alone must not trigger.
    wr(BTC_OFF_TRIG, 8'h80);
    wr(BTC_OFF_CTRL, 8'hD0);
    cpu_u.cyc(16'h5000, 8'h00, 5'b01000, 16'h0000);
    cpu_u.cyc(16'h1000, 8'h5A, 5'b00010, 16'h0000);
    cpu_u.idle(4);
    chk("fetched only", 16'h2, 16'(fb_n));
    repeat (3) cpu_u.cyc(16'h1001, 8'h00, 5'b01100, 16'h0000);
    cpu_u.cyc(16'h1000, 8'h5A, 5'b00010, 16'h0000);
    cpu_u.idle(4);
    chk("executed", 16'h3, 16'(fb_n));
    tally_and_finish();
  end
  // The whole sequence needs well under a thousand cycles.
  initial begin
    repeat (3000) @(posedge mclk);
    fails++;
    tally_and_finish();
  end
endmodule // tb_breakpoint_trace_capture
